// ===== verilog/shared_pin_mux_io_ports.sv
// Group1 shared pin mux with ports A, B and C and the clock-output pin.
// Assumes a synchronous 16-bit data-space register port driven by the CPU.
// Assumes port B peripherals supply their own pin drive and enable; clock sources arrive as data.
// What this block does
// - Mux bit 1 picks peripheral, 0 port
// - Direction bit 0 input, 1 output
// - Reads return pin level; writes drive outputs
// - Port bits act only under port selection
// - Select A: bits 0-3 port A, 8-15 port B
// - Select B: bits 0, 2-7 port C
// - Port A data 0-3, direction 8-11
// - Port B data 0-7, direction 8-15
// - Port C direction for pin n at n+8
// - Two-bit field chooses clock-output source
// - Port C pins 2, 3 inverted sense
// - Serial, SPI, interrupt pins stay outside here
// - Registers are 16-bit data-space words
`timescale 1ns/1ps
`include "pin_mux_map.svh"
module shared_pin_mux_io_ports (
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [15:0] ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  input  wire logic [1:0]  CLOCK_OUTPUT_SELECT_I,
  input  wire logic        WATCHDOG_CLOCK_I,
  input  wire logic        SYSTEM_CLOCK_I,
  input  wire logic        CPU_CLOCK_I,
  input  wire logic [3:0]  PORT_A_PAD_I,
  output logic      [3:0]  PORT_A_PAD_O,
  output logic      [3:0]  PORT_A_PAD_OE_O,
  input  wire logic [7:0]  PORT_B_PAD_I,
  output logic      [7:0]  PORT_B_PAD_O,
  output logic      [7:0]  PORT_B_PAD_OE_O,
  input  wire logic [7:0]  PORT_C_PAD_I,
  output logic      [7:0]  PORT_C_PAD_O,
  output logic      [7:0]  PORT_C_PAD_OE_O,
  output logic      [3:0]  CONVERTER_INPUT_O,
  input  wire logic [7:0]  PORT_B_PERIPH_OUT_I,
  input  wire logic [7:0]  PORT_B_PERIPH_OE_I,
  output logic      [7:0]  PORT_B_PERIPH_IN_O,
  output logic             CONVERTER_START_TRIGGER_O,
  input  wire logic        EXTERNAL_FLAG_OUTPUT_I,
  output logic             BRANCH_TEST_INPUT_O,
  output logic      [3:0]  CAPTURE_INPUT_O
);
  typedef struct packed {
    pin_mux_pkg::word_t sel_a;
    pin_mux_pkg::word_t sel_b;
    pin_mux_pkg::word_t port_a;
    pin_mux_pkg::word_t port_b;
    pin_mux_pkg::word_t port_c;
    pin_mux_pkg::word_t rdata;
  } state_t;
  state_t s;
  state_t next_s;

  logic [3:0] a_din;
  logic [7:0] b_din;
  logic [7:0] c_din;
  logic [7:0] b_per_in;
  logic [7:0] c_per_in;
  logic [7:0] c_port_sel;
  logic [7:0] c_per_out;
  logic [7:0] c_per_oe;
  logic       clk_src;
  pin_mux_pkg::clk_sel_t clk_sel;
  logic [4:0] wr_hit;
  logic [4:0] rd_hit;
  logic [7:0] c_periph_view;

  // The map header must agree with the fixed pad widths of the ports
  if (`PORT_A_PINS != 4 || `PORT_BC_PINS != 8) begin : g_bad_map
    $error("shared_pin_mux_io_ports pad counts do not match the port widths");
  end

  // Packs the read-back direction bits and sampled pin data into one read word
  function automatic pin_mux_pkg::word_t port_word(input logic [7:0] dir, input logic [7:0] din);
    port_word = {dir, din};
  endfunction

  // One-hot register hit; any other address, peripheral pin registers included, hits nothing
  function automatic logic [4:0] decode_addr(input logic [15:0] addr);
    case (addr)
      `PIN_SELECT_A_ADDR:          decode_addr = 5'h01;
      `PIN_SELECT_B_ADDR:          decode_addr = 5'h02;
      `PORT_A_DATA_DIRECTION_ADDR: decode_addr = 5'h04;
      `PORT_B_DATA_DIRECTION_ADDR: decode_addr = 5'h08;
      `PORT_C_DATA_DIRECTION_ADDR: decode_addr = 5'h10;
      default:                     decode_addr = 5'h00;
    endcase
  endfunction

  // A port C peripheral input sees its pin only while the peripheral owns it
  function automatic logic [7:0] periph_view(input logic [7:0] level, input logic [7:0] port_sel);
    periph_view = level & ~port_sel;
  endfunction

  assign wr_hit = WR_I ? decode_addr(ADDR_I) : 5'h00;
  assign rd_hit = RD_I ? decode_addr(ADDR_I) : 5'h00;

  always_comb begin
    next_s = s;
    if (wr_hit[0]) begin
      next_s.sel_a = WDATA_I & (`SEL_A_PORT_A_MASK | `SEL_A_PORT_B_MASK);
    end
    if (wr_hit[1]) begin
      next_s.sel_b = WDATA_I & `SEL_B_PORT_C_MASK;
    end
    if (wr_hit[2]) begin
      next_s.port_a = WDATA_I & `PORT_A_RW_MASK;
    end
    if (wr_hit[3]) begin
      next_s.port_b = WDATA_I;
    end
    if (wr_hit[4]) begin
      next_s.port_c = WDATA_I;
    end
    // A read in the same cycle as a write returns the old value
    case (rd_hit)
      5'h01:   next_s.rdata = s.sel_a;
      5'h02:   next_s.rdata = s.sel_b;
      5'h04:   next_s.rdata = port_word({4'h0, s.port_a[11:8]}, {4'h0, a_din});
      5'h08:   next_s.rdata = port_word(s.port_b[15:8], b_din);
      5'h10:   next_s.rdata = port_word(s.port_c[15:8], c_din);
      default: next_s.rdata = 16'h0000;
    endcase
    // After reset all mux bits are 0: port pins are inputs, C2 drives the flag, C3 feeds branch
    if (!RESET_N_I) begin
      next_s = '0;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    s <= next_s;
  end

  assign RDATA_O = s.rdata;

  // Port A: converter inputs have no output side
  logic [3:0] a_din_raw;
  port_pad_slice #(.WIDTH(`PORT_A_PINS)) u_port_a (
    .REF_CLK_I    (REF_CLK_I),
    .RESET_N_I    (RESET_N_I),
    .port_sel_i   (~s.sel_a[3:0]),
    .dir_i        (s.port_a[11:8]),
    .dout_i       (s.port_a[3:0]),
    .periph_out_i (4'h0),
    .periph_oe_i  (4'h0),
    .pad_in_i     (PORT_A_PAD_I),
    .pad_out_o    (PORT_A_PAD_O),
    .pad_oe_o     (PORT_A_PAD_OE_O),
    .periph_in_o  (CONVERTER_INPUT_O),
    .din_o        (a_din_raw)
  );
  assign a_din = a_din_raw;

  // Port B: compare and timer outputs drive through the peripheral's own enables
  port_pad_slice #(.WIDTH(`PORT_BC_PINS)) u_port_b (
    .REF_CLK_I    (REF_CLK_I),
    .RESET_N_I    (RESET_N_I),
    .port_sel_i   (~s.sel_a[15:8]),
    .dir_i        (s.port_b[15:8]),
    .dout_i       (s.port_b[7:0]),
    .periph_out_i (PORT_B_PERIPH_OUT_I),
    .periph_oe_i  (PORT_B_PERIPH_OE_I),
    .pad_in_i     (PORT_B_PAD_I),
    .pad_out_o    (PORT_B_PAD_O),
    .pad_oe_o     (PORT_B_PAD_OE_O),
    .periph_in_o  (b_per_in),
    .din_o        (b_din)
  );
  assign PORT_B_PERIPH_IN_O = b_per_in;

  // Pin 1 is port I/O only when the clock field is zero; pins 2, 3 inverted
  assign clk_sel = pin_mux_pkg::clk_sel_t'(CLOCK_OUTPUT_SELECT_I);
  always_comb begin
    c_port_sel    = ~s.sel_b[7:0];
    c_port_sel[1] = (CLOCK_OUTPUT_SELECT_I == `CLK_OUT_PORT_IO);
    c_port_sel[2] = s.sel_b[2];
    c_port_sel[3] = s.sel_b[3];
    case (clk_sel)
      pin_mux_pkg::CLK_SEL_WATCHDOG: clk_src = WATCHDOG_CLOCK_I;
      pin_mux_pkg::CLK_SEL_SYSTEM:   clk_src = SYSTEM_CLOCK_I;
      pin_mux_pkg::CLK_SEL_CPU:      clk_src = CPU_CLOCK_I;
      // Field 00 leaves pin 1 to the port, so no clock is offered there
      default:                       clk_src = 1'b0;
    endcase
    c_per_out    = 8'h00;
    c_per_oe     = 8'h00;
    c_per_out[1] = clk_src;
    c_per_oe[1]  = 1'b1;
    c_per_out[2] = EXTERNAL_FLAG_OUTPUT_I;
    c_per_oe[2]  = 1'b1;
  end

  // Port C: only the flag and clock pins have a peripheral driver
  port_pad_slice #(.WIDTH(`PORT_BC_PINS)) u_port_c (
    .REF_CLK_I    (REF_CLK_I),
    .RESET_N_I    (RESET_N_I),
    .port_sel_i   (c_port_sel),
    .dir_i        (s.port_c[15:8]),
    .dout_i       (s.port_c[7:0]),
    .periph_out_i (c_per_out),
    .periph_oe_i  (c_per_oe),
    .pad_in_i     (PORT_C_PAD_I),
    .pad_out_o    (PORT_C_PAD_O),
    .pad_oe_o     (PORT_C_PAD_OE_O),
    .periph_in_o  (c_per_in),
    .din_o        (c_din)
  );

  // Pins 1 and 2 feed no peripheral input, so their view bits stay unused
  assign c_periph_view             = periph_view(c_per_in, c_port_sel);
  assign CONVERTER_START_TRIGGER_O = c_periph_view[0];
  assign BRANCH_TEST_INPUT_O       = c_periph_view[3];
  assign CAPTURE_INPUT_O           = c_periph_view[7:4];

  // Group2 pins (serial, SPI, external interrupts) are not routed here; their own registers rule them
endmodule

// ===== verilog/pin_mux_map.svh
// Register offsets, field positions and reset values of the shared pin mux.
// Assumes a 16-bit data-space register port on the CPU side.
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH
`define PIN_SELECT_A_ADDR           16'h7090
`define PIN_SELECT_B_ADDR           16'h7092
`define PORT_A_DATA_DIRECTION_ADDR  16'h7098
`define PORT_B_DATA_DIRECTION_ADDR  16'h709A
`define PORT_C_DATA_DIRECTION_ADDR  16'h709C
`define DATA_LSB                    0
`define DIR_LSB                     8
`define PORT_A_PINS                 4
`define PORT_BC_PINS                8
`define SEL_A_PORT_A_MASK           16'h000F
`define SEL_A_PORT_B_MASK           16'hFF00
`define SEL_B_PORT_C_MASK           16'h00FD
`define PORT_A_RW_MASK              16'h0F0F
`define SELECT_RESET                16'h0000
`define PORT_RESET                  16'h0000
`define CLK_OUT_PORT_IO             2'h0
`define CLK_OUT_WATCHDOG            2'h1
`define CLK_OUT_SYSTEM              2'h2
`define CLK_OUT_CPU                 2'h3
`endif

// ===== verilog/pin_mux_pkg.sv
// Types shared by the shared pin mux files.
// Assumes the map header supplies all numbers.
package pin_mux_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {
    CLK_SEL_PORT_IO,
    CLK_SEL_WATCHDOG,
    CLK_SEL_SYSTEM,
    CLK_SEL_CPU
  } clk_sel_t;
endpackage

// ===== verilog/port_pad_slice.sv
// One port of WIDTH pad slices, 1 to 8: mux, direction, output data and input sampling.
// Assumes pads resolved by the surroundings from the output enables.
`timescale 1ns/1ps
module port_pad_slice #(
  parameter int WIDTH = 8
) (
  input  wire logic             REF_CLK_I,
  input  wire logic             RESET_N_I,
  input  wire logic [WIDTH-1:0] port_sel_i,
  input  wire logic [WIDTH-1:0] dir_i,
  input  wire logic [WIDTH-1:0] dout_i,
  input  wire logic [WIDTH-1:0] periph_out_i,
  input  wire logic [WIDTH-1:0] periph_oe_i,
  input  wire logic [WIDTH-1:0] pad_in_i,
  output logic      [WIDTH-1:0] pad_out_o,
  output logic      [WIDTH-1:0] pad_oe_o,
  output logic      [WIDTH-1:0] periph_in_o,
  output logic      [WIDTH-1:0] din_o
);
  // A port never carries more than eight pins
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("port_pad_slice WIDTH must be 1 to 8");
  end

  typedef struct packed {
    logic [WIDTH-1:0] sample;
  } state_t;
  state_t s;
  state_t next_s;

  always_comb begin
    next_s = s;
    next_s.sample = pad_in_i;
    if (!RESET_N_I) begin
      next_s = '0;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    s <= next_s;
  end

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (port_sel_i[i]) begin
        pad_out_o[i] = dout_i[i];
        pad_oe_o[i]  = dir_i[i];
      end else begin
        pad_out_o[i] = periph_out_i[i];
        pad_oe_o[i]  = periph_oe_i[i];
      end
    end
  end

  assign periph_in_o = pad_in_i;
  assign din_o       = s.sample;
endmodule

// ===== verification/pin_mux_checker.sv
// Checker: read timing, select A mask and peripheral input routing of the pin mux.
// Assumes binding to the top module; registers are seen only through reads.
`timescale 1ns/1ps
module pin_mux_checker (
  input wire logic        REF_CLK_I,
  input wire logic        RESET_N_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic [3:0]  PORT_A_PAD_I,
  input wire logic [7:0]  PORT_B_PAD_I,
  input wire logic [7:0]  PORT_C_PAD_I,
  input wire logic [3:0]  CONVERTER_INPUT_O,
  input wire logic [7:0]  PORT_B_PERIPH_IN_O,
  input wire logic        BRANCH_TEST_INPUT_O,
  input wire logic [3:0]  CAPTURE_INPUT_O,
  input wire logic [1:0]  CLOCK_OUTPUT_SELECT_I,
  input wire logic        WATCHDOG_CLOCK_I,
  input wire logic        SYSTEM_CLOCK_I,
  input wire logic        CPU_CLOCK_I,
  input wire logic [7:0]  PORT_C_PAD_O,
  input wire logic [7:0]  PORT_C_PAD_OE_O,
  input wire logic        CONVERTER_START_TRIGGER_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence sel_wr; WR_I && ADDR_I == 16'h7090; endsequence
  sequence sel_rd; RD_I && ADDR_I == 16'h7090; endsequence
  idle_read_zero_a: assert property (!RD_I |=> RDATA_O == 16'h0000) else $error("idle read");
  unmapped_zero_a: assert property (RD_I &&
    !(ADDR_I inside {16'h7090, 16'h7092, 16'h7098, 16'h709A, 16'h709C}) |=> RDATA_O == 16'h0000)
    else $error("unmapped read");
  sel_readback_a: assert property (sel_wr ##1 !WR_I ##1 sel_rd
    |=> RDATA_O == ($past(WDATA_I, 3) & 16'hFF0F)) else $error("select readback");
  pin_echo_a: assert property (RD_I && ADDR_I == 16'h709A && $past(RESET_N_I)
    |=> RDATA_O[7:0] == $past(PORT_B_PAD_I, 2)) else $error("pin readback");
  conv_raw_a: assert property (CONVERTER_INPUT_O == PORT_A_PAD_I) else $error("converter input");
  timer_raw_a: assert property (PORT_B_PERIPH_IN_O == PORT_B_PAD_I) else $error("port B input");
  capture_gate_a: assert property ((CAPTURE_INPUT_O & ~PORT_C_PAD_I[7:4]) == 4'h0) else $error("capture");
  branch_gate_a: assert property (BRANCH_TEST_INPUT_O |-> PORT_C_PAD_I[3]) else $error("branch input");
  trig_gate_a: assert property (CONVERTER_START_TRIGGER_O |-> PORT_C_PAD_I[0]) else $error("start trigger");
  clock_pin_a: assert property (CLOCK_OUTPUT_SELECT_I != 2'h0 |-> PORT_C_PAD_OE_O[1] && PORT_C_PAD_O[1] ==
    (CLOCK_OUTPUT_SELECT_I == 2'h1 ? WATCHDOG_CLOCK_I : CLOCK_OUTPUT_SELECT_I == 2'h2 ? SYSTEM_CLOCK_I : CPU_CLOCK_I))
    else $error("clock pin");
endmodule
bind shared_pin_mux_io_ports pin_mux_checker mon_i (.REF_CLK_I, .RESET_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
  .RDATA_O, .PORT_A_PAD_I, .PORT_B_PAD_I, .PORT_C_PAD_I, .CONVERTER_INPUT_O, .PORT_B_PERIPH_IN_O,
  .BRANCH_TEST_INPUT_O, .CAPTURE_INPUT_O, .CLOCK_OUTPUT_SELECT_I, .WATCHDOG_CLOCK_I, .SYSTEM_CLOCK_I,
  .CPU_CLOCK_I, .PORT_C_PAD_O, .PORT_C_PAD_OE_O, .CONVERTER_START_TRIGGER_O);

// ===== verification/pad_board.sv
// Board on one port: drives each pad unless the device enables its driver.
// Assumes board drivers are weaker than the device's.
`timescale 1ns/1ps
module pad_board #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] pad_out_i,
  input  wire logic [W-1:0] pad_oe_i,
  input  wire logic [W-1:0] board_i,
  output logic      [W-1:0] pad_level_o
);
  assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & board_i);
endmodule

// ===== verification/tb.sv
// Bench: register scenarios on ports A, B, C and the clock-output pin.
// Assumes design, board model and checker compiled first.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, flag = 1'b0;
  logic [1:0] csel = 2'h0;
  logic [2:0] src = 3'h0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
  logic [7:0] bpo = 8'h3C, bpoe = 8'h0F, bext = 8'h00, cext = 8'hA9;
  logic [3:0] aext = 4'h0, ao, aoe, alv, conv, cap;
  logic [7:0] bo, boe, blv, bpin, co, coe, clv;
  logic trig, br;
  int n_mismatch = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  shared_pin_mux_io_ports dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .CLOCK_OUTPUT_SELECT_I(csel), .WATCHDOG_CLOCK_I(src[0]),
    .SYSTEM_CLOCK_I(src[1]), .CPU_CLOCK_I(src[2]), .PORT_A_PAD_I(alv), .PORT_A_PAD_O(ao),
    .PORT_A_PAD_OE_O(aoe), .PORT_B_PAD_I(blv), .PORT_B_PAD_O(bo), .PORT_B_PAD_OE_O(boe), .PORT_C_PAD_I(clv),
    .PORT_C_PAD_O(co), .PORT_C_PAD_OE_O(coe), .CONVERTER_INPUT_O(conv), .PORT_B_PERIPH_OUT_I(bpo),
    .PORT_B_PERIPH_OE_I(bpoe), .PORT_B_PERIPH_IN_O(bpin), .CONVERTER_START_TRIGGER_O(trig),
    .EXTERNAL_FLAG_OUTPUT_I(flag), .BRANCH_TEST_INPUT_O(br), .CAPTURE_INPUT_O(cap));
  pad_board #(.W(4)) pa (.pad_out_i(ao), .pad_oe_i(aoe), .board_i(aext), .pad_level_o(alv));
  pad_board #(.W(8)) pb (.pad_out_i(bo), .pad_oe_i(boe), .board_i(bext), .pad_level_o(blv));
  pad_board #(.W(8)) pc (.pad_out_i(co), .pad_oe_i(coe), .board_i(cext), .pad_level_o(clv));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask
  task automatic t_reset;
    rd_reg(16'h7092, 16'h0000, "sel_b");
    chk("b pads", {boe, bo & boe}, 16'h0000);
    chk("c oe", {8'h00, coe}, 16'h0004);
  endtask
  task automatic t_masks;
    wr_reg(16'h7090, 16'hFFFF);
    rd_reg(16'h7090, 16'hFF0F, "sel_a");
    wr_reg(16'h7092, 16'hFFFF);
    rd_reg(16'h7092, 16'h00FD, "sel_b");
    rd_reg(16'h7094, 16'h0000, "unmapped");
    chk("c inputs", {10'h000, trig, cap, br}, 16'h0034);
  endtask
  task automatic t_portb;
    wr_reg(16'h7090, 16'h000F);
    wr_reg(16'h709A, 16'hF055);
    chk("b out", {boe, bo & boe}, 16'hF050);
    @(posedge clk);
    bext <= 8'h06;
    repeat (2) @(posedge clk);
    rd_reg(16'h709A, 16'hF056, "b data");
  endtask
  task automatic t_porta;
    wr_reg(16'h7090, 16'hFF00);
    wr_reg(16'h7098, 16'hFFF5);
    chk("a out", {8'h00, aoe, ao}, 16'h00F5);
    chk("b back", {boe, bo & boe}, 16'h0F0C);
    rd_reg(16'h7098, 16'h0F05, "a data");
  endtask
  task automatic t_portc;
    wr_reg(16'h7092, 16'h0000);
    wr_reg(16'h709C, 16'h0202);
    @(posedge clk);
    flag <= 1'b1;
    #1;
    chk("c out", {coe, co & 8'h06}, 16'h0606);
    chk("branch", {15'h0000, br}, 16'h0001);
    for (int s = 1; s < 4; s++) begin
      @(posedge clk);
      csel <= 2'(s);
      src <= ~(3'h1 << (s - 1));
      #1;
      chk("clock pin", {14'h0000, coe[1], co[1]}, 16'h0002);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_masks;
    t_portb;
    t_porta;
    t_portc;
    end_of_test;
  end
  initial begin
    #5000;
    n_mismatch++;
    end_of_test;
  end
endmodule
